/* hdl/ufc_pkg.sv */
// Constants and types for the UART flow-control and configuration-store block
package ufc_pkg;

  localparam int          RX_WATERMARK  = 383;
  localparam int          SER_LEN_MAX   = 63;
  localparam int          DESC_LEN_MAX  = 126;
  localparam logic [5:0]  SER_LEN_DEF   = 6'h08;
  localparam logic [7:0]  PWR_ATTR_DEF  = 8'h80;
  localparam logic [7:0]  PWR_MAX_DEF   = 8'h32;
  localparam logic [7:0]  GPIO_MODE_DEF = 8'h00;
  localparam logic [7:0]  FLAGS_DEF     = 8'h0F;

  localparam int          FLG_FLUSH_TX  = 0;
  localparam int          FLG_FLUSH_RX  = 1;
  localparam int          FLG_SUSP_PP   = 2;
  localparam int          FLG_SUSPN_PP  = 3;
  localparam int          FLG_POL_LOW   = 4;

  localparam logic [9:0]  OTP_VID       = 10'h000;
  localparam logic [9:0]  OTP_PID       = 10'h002;
  localparam logic [9:0]  OTP_ATTR      = 10'h004;
  localparam logic [9:0]  OTP_MAXP      = 10'h005;
  localparam logic [9:0]  OTP_REL       = 10'h006;
  localparam logic [9:0]  OTP_GPIO      = 10'h008;
  localparam logic [9:0]  OTP_FLAGS     = 10'h009;
  localparam logic [9:0]  OTP_SER_LEN   = 10'h00A;
  localparam logic [9:0]  OTP_DESC_LEN  = 10'h00B;
  localparam logic [9:0]  OTP_SER_STR   = 10'h010;
  localparam logic [9:0]  OTP_DESC_STR  = 10'h050;

  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_GPIO      = 8'h08;
  localparam logic [7:0]  REG_PROG_ADDR = 8'h0C;
  localparam logic [7:0]  REG_PROG_DATA = 8'h10;
  localparam logic [7:0]  REG_CFG_ADDR  = 8'h14;
  localparam logic [7:0]  REG_CFG_DATA  = 8'h18;
  localparam logic [7:0]  REG_IDS       = 8'h1C;
  localparam logic [7:0]  REG_DESC      = 8'h20;
  localparam logic [7:0]  REG_MODES     = 8'h24;

  localparam int          CTRL_FLOW_EN  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  typedef enum logic [1:0] {
    GPIO_IN  = 2'h0,
    GPIO_OD  = 2'h1,
    GPIO_PP  = 2'h2,
    GPIO_ALT = 2'h3
  } ufc_gpio_mode_e;

endpackage : ufc_pkg

/* hdl/ufc_flow.sv */
// RTS generation from receive fill level and CTS gating of the transmitter
`timescale 1ns/100ps
module ufc_flow import ufc_pkg::*; #(
  parameter int LVL_W = 10
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             flow_en,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic             cts_n,
  input  wire logic             tx_start,
  output logic                  rts_n,
  output logic                  tx_allow,
  output logic [1:0]            cts_bytes
);

  logic                   rts_n_reg;
  logic [1:0]             cts_bytes_reg;
  wire                    at_mark = rx_level >= LVL_W'(RX_WATERMARK);
  wire                    held    = flow_en && cts_n;

  // Disabled flow control keeps RTS asserted so the far end never stalls
  assign tx_allow = !held;
  assign rts_n    = rts_n_reg;
  assign cts_bytes = cts_bytes_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n_reg     <= 1'b0;
      cts_bytes_reg <= 2'h0;
    end else begin
      rts_n_reg     <= flow_en && at_mark;
      if (!held)
        cts_bytes_reg <= 2'h0;
      else if (tx_start && cts_bytes_reg != 2'h3)
        cts_bytes_reg <= cts_bytes_reg + 2'h1;
    end
  end

  rts_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flow_en && at_mark |=> rts_n) else $error("RTS low at watermark");
  rts_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flow_en && !at_mark |=> !rts_n) else $error("RTS high below watermark");
  rts_resume_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(at_mark) && flow_en ##1 flow_en |-> !rts_n) else $error("RTS stuck");
  flow_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !flow_en |-> tx_allow ##1 !rts_n) else $error("flow pins active while off");
  cts_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flow_en && cts_n |-> !tx_allow && cts_bytes <= 2'h2) else $error("CTS ignored");

endmodule : ufc_flow

/* hdl/ufc_cfg_store.sv */
// One-time programmable configuration store with default fallback
`timescale 1ns/100ps
module ufc_cfg_store import ufc_pkg::*; #(
  parameter int          DEPTH   = 1024,
  parameter logic [15:0] VID_DEF = 16'h1234, // Arbitrary value
  parameter logic [15:0] PID_DEF = 16'h5678, // Arbitrary value
  parameter logic [15:0] REL_DEF = 16'h0001, // Arbitrary value
  parameter logic [63:0] SER_DEF = 64'h3030_3030_3030_3031 // Arbitrary value
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        prog_en,
  input  wire logic [9:0]  prog_addr,
  input  wire logic [7:0]  prog_data,
  input  wire logic [9:0]  rd_addr,
  output logic [7:0]       rd_data,
  output logic             programmed,
  output logic [15:0]      vid,
  output logic [15:0]      pid,
  output logic [15:0]      rel,
  output logic [7:0]       pwr_attr,
  output logic [7:0]       pwr_max,
  output logic [7:0]       gpio_mode,
  output logic [7:0]       flags,
  output logic [5:0]       ser_len,
  output logic [6:0]       desc_len
);

  // Blank fuses read zero; programming can only set bits, never clear them
  logic [7:0] mem [DEPTH];
  logic       prog_reg;
  logic [7:0] dflt;
  wire  [9:0] ser_off = rd_addr - OTP_SER_STR;
  wire  [7:0] ser_raw = mem[OTP_SER_LEN];
  wire  [7:0] dsc_raw = mem[OTP_DESC_LEN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= 8'h00;
    end else if (prog_en) begin
      prog_reg       <= 1'b1;
      mem[prog_addr] <= mem[prog_addr] | prog_data;
    end
  end

  assign programmed = prog_reg;
  assign vid      = prog_reg ? {mem[OTP_VID+10'h1], mem[OTP_VID]} : VID_DEF;
  assign pid      = prog_reg ? {mem[OTP_PID+10'h1], mem[OTP_PID]} : PID_DEF;
  assign rel      = prog_reg ? {mem[OTP_REL+10'h1], mem[OTP_REL]} : REL_DEF;
  assign pwr_attr = prog_reg ? mem[OTP_ATTR] : PWR_ATTR_DEF;
  assign pwr_max  = prog_reg ? mem[OTP_MAXP] : PWR_MAX_DEF;
  assign gpio_mode = prog_reg ? mem[OTP_GPIO] : GPIO_MODE_DEF;
  assign flags    = prog_reg ? mem[OTP_FLAGS] : FLAGS_DEF;
  assign ser_len  = !prog_reg ? SER_LEN_DEF :
                    ser_raw > 8'(SER_LEN_MAX) ? 6'(SER_LEN_MAX) : ser_raw[5:0];
  assign desc_len = !prog_reg ? 7'h00 :
                    dsc_raw > 8'(DESC_LEN_MAX) ? 7'(DESC_LEN_MAX) : dsc_raw[6:0];

  always_comb begin
    dflt = 8'h00;
    unique case (rd_addr)
      OTP_VID:         dflt = VID_DEF[7:0];
      OTP_VID + 10'h1: dflt = VID_DEF[15:8];
      OTP_PID:         dflt = PID_DEF[7:0];
      OTP_PID + 10'h1: dflt = PID_DEF[15:8];
      OTP_ATTR:        dflt = PWR_ATTR_DEF;
      OTP_MAXP:        dflt = PWR_MAX_DEF;
      OTP_REL:         dflt = REL_DEF[7:0];
      OTP_REL + 10'h1: dflt = REL_DEF[15:8];
      OTP_FLAGS:       dflt = FLAGS_DEF;
      OTP_SER_LEN:     dflt = {2'h0, SER_LEN_DEF};
      default:         dflt = (ser_off < 10'(SER_LEN_DEF)) ?
                              SER_DEF[8'(ser_off) * 8 +: 8] : 8'h00;
    endcase
  end

  assign rd_data = prog_reg ? mem[rd_addr] : dflt;

  dflt_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !programmed |-> pwr_attr == 8'h80 && pwr_max == 8'h32) else $error("bad power");
  ser_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ser_len <= 6'h3F && (!programmed -> ser_len == 6'h08)) else $error("bad serial len");
  desc_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    desc_len <= 7'h7E) else $error("description too long");
  prog_sticks_a: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_en |=> programmed && (mem[$past(prog_addr)] & $past(prog_data)) ==
    $past(prog_data)) else $error("program write lost");

endmodule : ufc_cfg_store

/* hdl/ufc_top.sv */
// UART flow control, configuration store and AHB-Lite register slave
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module ufc_top import ufc_pkg::*; #(
  parameter int          LVL_W   = 10,
  parameter int          OTP_DEP = 1024,
  parameter logic [15:0] TOG_DIV = 16'h0FFF
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic             cts_n,
  output logic                  rts_n,
  input  wire logic             tx_start,
  output logic                  tx_allow,
  input  wire logic             tx_busy,
  input  wire logic             rx_busy,
  input  wire logic             port_open,
  output logic                  flush_tx,
  output logic                  flush_rx,
  input  wire logic [3:0]       gpio_i,
  output logic [3:0]            gpio_o,
  output logic [3:0]            gpio_oe,
  output logic                  susp_pp,
  output logic                  susp_n_pp
);

  function automatic logic pin_oe(input logic [1:0] mode, input logic val);
    unique case (mode)
      GPIO_IN: pin_oe = 1'b0;
      GPIO_OD: pin_oe = !val;
      default: pin_oe = 1'b1;
    endcase
  endfunction : pin_oe

  // Bus, register, flush, pin and activity-indicator state
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] ctrl_reg;
  logic [3:0]  gpio_out_reg;
  logic [9:0]  prog_addr_reg;
  logic [9:0]  cfg_addr_reg;
  logic        flush_tx_reg;
  logic        flush_rx_reg;
  logic [3:0]  gpio_o_reg;
  logic [3:0]  gpio_oe_reg;
  logic [15:0] tog_cnt_reg;
  logic        tog_tx_reg;
  logic        tog_rx_reg;
  logic [31:0] rd_mux;

  // Store outputs and flow-control byte count
  logic [7:0]  cfg_byte;
  logic        programmed;
  logic [15:0] vid;
  logic [15:0] pid;
  logic [15:0] rel;
  logic [7:0]  pwr_attr;
  logic [7:0]  pwr_max;
  logic [7:0]  gpio_mode;
  logic [7:0]  flags;
  logic [5:0]  ser_len;
  logic [6:0]  desc_len;
  logic [1:0]  cts_bytes;

  wire         addr_ok   = hsel && htrans[1] && hready;
  wire         rd_req    = addr_ok && !hwrite;
  wire [7:0]   rd_addr   = haddr[7:0];
  wire         in_map    = haddr[31:8] == 24'h0;
  wire         wr_ctrl   = wr_pend_reg && wr_addr_reg == REG_CTRL;
  wire         wr_gpio   = wr_pend_reg && wr_addr_reg == REG_GPIO;
  wire         wr_paddr  = wr_pend_reg && wr_addr_reg == REG_PROG_ADDR;
  wire         wr_pdata  = wr_pend_reg && wr_addr_reg == REG_PROG_DATA;
  wire         wr_caddr  = wr_pend_reg && wr_addr_reg == REG_CFG_ADDR;
  wire         flow_en   = ctrl_reg[CTRL_FLOW_EN];
  wire         pol_low   = flags[FLG_POL_LOW];
  // Transceiver enable follows the transmitter; polarity comes from the store
  wire         xcvr_ctl  = tx_busy ^ pol_low;
  wire         tog_tick  = tog_cnt_reg == TOG_DIV;
  wire [3:0]   alt_val   = {gpio_out_reg[3], xcvr_ctl, tog_rx_reg, tog_tx_reg};
  wire [3:0]   pin_val;

  // Single-cycle slave: every transfer completes with no wait state
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign flush_tx  = flush_tx_reg;
  assign flush_rx  = flush_rx_reg;
  assign gpio_o    = gpio_o_reg;
  assign gpio_oe   = gpio_oe_reg;
  assign susp_pp   = flags[FLG_SUSP_PP];
  assign susp_n_pp = flags[FLG_SUSPN_PP];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_map) begin
      unique case (rd_addr)
        REG_CTRL:      rd_mux = ctrl_reg;
        REG_STATUS:    rd_mux = {6'h00, rx_level, 10'h000, cts_bytes,
                                 programmed, tx_allow, cts_n, rts_n};
        REG_GPIO:      rd_mux = {24'h0, gpio_i, gpio_out_reg};
        REG_PROG_ADDR: rd_mux = {22'h0, prog_addr_reg};
        REG_CFG_ADDR:  rd_mux = {22'h0, cfg_addr_reg};
        REG_CFG_DATA:  rd_mux = {24'h0, cfg_byte};
        REG_IDS:       rd_mux = {pid, vid};
        REG_DESC:      rd_mux = {rel, pwr_max, pwr_attr};
        REG_MODES:     rd_mux = {1'b0, desc_len, 2'h0, ser_len, flags, gpio_mode};
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite && in_map;
      wr_addr_reg <= rd_addr;
      if (rd_req)
        hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg      <= CTRL_RESET;
      gpio_out_reg  <= 4'h0;
      prog_addr_reg <= 10'h000;
      cfg_addr_reg  <= 10'h000;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= {31'h0, hwdata[CTRL_FLOW_EN]};
      if (wr_gpio)
        gpio_out_reg <= hwdata[3:0];
      if (wr_paddr)
        prog_addr_reg <= hwdata[9:0];
      if (wr_caddr)
        cfg_addr_reg <= hwdata[9:0];
    end
  end

  // Port open flushes only the FIFOs the store asks for
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_tx_reg <= 1'b0;
      flush_rx_reg <= 1'b0;
    end else begin
      flush_tx_reg <= port_open && flags[FLG_FLUSH_TX];
      flush_rx_reg <= port_open && flags[FLG_FLUSH_RX];
    end
  end

  // Activity indicators idle high and toggle while data moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_cnt_reg <= 16'h0000;
      tog_tx_reg  <= 1'b1;
      tog_rx_reg  <= 1'b1;
    end else begin
      tog_cnt_reg <= tog_tick ? 16'h0000 : tog_cnt_reg + 16'h0001;
      if (!tx_busy)
        tog_tx_reg <= 1'b1;
      else if (tog_tick)
        tog_tx_reg <= !tog_tx_reg;
      if (!rx_busy)
        tog_rx_reg <= 1'b1;
      else if (tog_tick)
        tog_rx_reg <= !tog_rx_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      wire [1:0] mode = gpio_mode[2*g+1:2*g];
      assign pin_val[g] = (mode == GPIO_ALT) ? alt_val[g] : gpio_out_reg[g];
    end
  endgenerate

  // Pins stay inputs until the store selects another mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_o_reg  <= 4'h0;
      gpio_oe_reg <= 4'h0;
    end else begin
      gpio_o_reg <= pin_val;
      for (int i = 0; i < 4; i++)
        gpio_oe_reg[i] <= pin_oe(gpio_mode[2*i+:2], pin_val[i]);
    end
  end

  ufc_flow #(
    .LVL_W     (LVL_W)
  ) u_flow (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .flow_en   (flow_en),
    .rx_level  (rx_level),
    .cts_n     (cts_n),
    .tx_start  (tx_start),
    .rts_n     (rts_n),
    .tx_allow  (tx_allow),
    .cts_bytes (cts_bytes)
  );

  // Software on the host side programs the store through these registers
  ufc_cfg_store #(
    .DEPTH     (OTP_DEP)
  ) u_store (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .prog_en   (wr_pdata),
    .prog_addr (prog_addr_reg),
    .prog_data (hwdata[7:0]),
    .rd_addr   (cfg_addr_reg),
    .rd_data   (cfg_byte),
    .programmed(programmed),
    .vid       (vid),
    .pid       (pid),
    .rel       (rel),
    .pwr_attr  (pwr_attr),
    .pwr_max   (pwr_max),
    .gpio_mode (gpio_mode),
    .flags     (flags),
    .ser_len   (ser_len),
    .desc_len  (desc_len)
  );

  gpio_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !programmed ##1 !programmed |-> gpio_oe == 4'h0) else $error("pin driven by default");
  flush_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !programmed && port_open |=> flush_tx && flush_rx) else $error("no flush on open");
  xcvr_pol_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !programmed |-> xcvr_ctl == tx_busy) else $error("transceiver polarity wrong");
  dflt_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !programmed |-> flags == 8'h0F && gpio_mode == 8'h00) else $error("bad defaults");
  bus_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_req && in_map && rd_addr == REG_IDS |=> hrdata == {$past(pid), $past(vid)})
    else $error("ID read wrong");
  prog_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && hwrite && in_map && rd_addr == REG_PROG_DATA |=> ##1 programmed)
    else $error("program write ignored");

endmodule : ufc_top

/* tb/ufc_uart_partner.sv */
// Far-side UART model: its receive fill level drives CTS
`timescale 1ns/100ps
module ufc_uart_partner #(
  parameter int FULL = 6
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tx_start,
  input  wire logic drain,
  output logic      cts_n,
  output logic [7:0] late,
  output logic [7:0] fill
);
  logic pop;
  assign pop = drain && (fill != 8'h00);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill  <= 8'h00;
      cts_n <= 1'b0;
      late  <= 8'h00;
    end else begin
      fill  <= fill + {7'h00, tx_start} - {7'h00, pop};
      // Registered, so CTS lags the byte that filled it, as a real UART would
      cts_n <= (fill >= FULL);
      if (cts_n && tx_start) late <= late + 8'h01;
    end
  end
endmodule : ufc_uart_partner

/* tb/tb.sv */
// Self-checking bench for the flow-control, store and register slave
`timescale 1ns/100ps
module tb;
  import ufc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_start, port_open, drain;
  logic        cts_n, rts_n, tx_allow, flush_tx, flush_rx, susp_pp, susp_n_pp, ok, tx_busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  rx_level, lvl;
  logic [3:0]  gpio_i, gpio_o, gpio_oe;
  logic [7:0]  late, fill, late0;
  int          fails, n_tests;
  string       names[$];
  logic [31:0] exps[$];
  logic [31:0] seens[$];
  event        got;

  ufc_top #(.TOG_DIV(16'h0004)) i_ufc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_level(rx_level),
    .cts_n(cts_n), .rts_n(rts_n), .tx_start(tx_start), .tx_allow(tx_allow),
    .tx_busy(tx_busy), .rx_busy(1'b0), .port_open(port_open), .flush_tx(flush_tx),
    .flush_rx(flush_rx), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .susp_pp(susp_pp), .susp_n_pp(susp_n_pp));

  ufc_uart_partner #(.FULL(6)) i_ufc_uart_partner (
    .hclk(hclk), .hresetn(hresetn), .tx_start(tx_start), .drain(drain),
    .cts_n(cts_n), .late(late), .fill(fill));

  task automatic finish_test();
    drain_notes();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic compare_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : compare_word

  // Several notes may land in one time step, so every pending note is taken
  task automatic drain_notes();
    while (names.size() > 0)
      compare_word(names.pop_front(), exps.pop_front(), seens.pop_front());
  endtask : drain_notes

  always @(got) begin
    drain_notes();
  end

  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  // Address phase, then data phase; read data is taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic expect_port(input string nm, input logic [31:0] e, input logic [31:0] v);
    names.push_back(nm);
    exps.push_back(e);
    seens.push_back(v);
    ->got;
  endtask : expect_port

  task automatic expect_rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    expect_port(nm, e, rd);
  endtask : expect_rd

  function automatic logic [31:0] st(input logic [9:0] l, input logic c, input logic al,
                                     input logic r, input logic p);
    return {6'h00, l, 10'h000, 2'b00, p, al, c, r};
  endfunction : st

  task automatic send_bytes(input int n, input logic gate);
    repeat (n) begin
      @(negedge hclk);
      ok = tx_allow | ~gate;
      @(posedge hclk);
      tx_start <= ok;
      @(posedge hclk);
      tx_start <= 1'b0;
    end
  endtask : send_bytes

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, tx_start, port_open, drain, tx_busy} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize    = 3'h2;
    rx_level = 10'd400;
    fails    = 0;
    n_tests  = 0;
    void'($urandom(60));
    gpio_i   = 4'($urandom());
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    expect_rd({24'h0, REG_CTRL}, CTRL_RESET, "ctrl_reset");
    expect_port("hresp", 32'h0, {31'h0, hresp});
    expect_port("susp_def", 32'h3, {30'h0, susp_pp, susp_n_pp});
    expect_rd({24'h0, REG_MODES}, 32'h0008_0F00, "modes_def");
    expect_rd({24'h0, REG_DESC}, 32'h0001_3280, "desc_def");
    expect_rd({24'h0, REG_IDS}, 32'h5678_1234, "ids_def");
    bus(1'b1, 32'h0000_003C, 32'hFFFF_FFFF);
    expect_rd(32'h0000_003C, 32'h0, "reserved");
    expect_rd(32'h0000_0100, 32'h0, "unmapped");
    send_bytes(8, 1'b0);
    expect_rd({24'h0, REG_STATUS}, st(10'd400, 1'b1, 1'b1, 1'b0, 1'b0), "flow_off");
    drain <= 1'b1;
    repeat (12) @(posedge hclk);
    drain <= 1'b0;
    bus(1'b1, {24'h0, REG_CTRL}, 32'h0000_0001);
    lvl = 10'($urandom_range(0, 382));
    rx_level <= lvl;
    repeat (2) @(posedge hclk);
    expect_rd({24'h0, REG_STATUS}, st(lvl, 1'b0, 1'b1, 1'b0, 1'b0), "rts_low");
    rx_level <= 10'd383;
    repeat (2) @(posedge hclk);
    expect_rd({24'h0, REG_STATUS}, st(10'd383, 1'b0, 1'b1, 1'b1, 1'b0), "rts_mark");
    rx_level <= 10'd382;
    repeat (2) @(posedge hclk);
    expect_rd({24'h0, REG_STATUS}, st(10'd382, 1'b0, 1'b1, 1'b0, 1'b0), "rts_back");
    // Bytes started while flow control was off are not charged to this phase
    late0 = late;
    send_bytes(12, 1'b1);
    expect_port("late_bytes", 32'h1, {31'h0, (late - late0) <= 8'h02});
    // One byte was already launched in the cycle in which CTS rose
    expect_rd({24'h0, REG_STATUS}, st(10'd382, 1'b1, 1'b0, 1'b0, 1'b0) | 32'h0000_0010,
              "cts_gate");
    drain <= 1'b1;
    repeat (12) @(posedge hclk);
    drain <= 1'b0;
    port_open <= 1'b1;
    @(posedge hclk);
    port_open <= 1'b0;
    @(negedge hclk);
    expect_port("flush", 32'h3, {30'h0, flush_tx, flush_rx});
    @(negedge hclk);
    expect_port("flush_end", 32'h0, {30'h0, flush_tx, flush_rx});
    @(posedge hclk);
    bus(1'b1, {24'h0, REG_GPIO}, 32'h0000_0005);
    expect_rd({24'h0, REG_GPIO}, {24'h0, gpio_i, 4'h5}, "gpio");
    expect_port("gpio_oe", 32'h0, {28'h0, gpio_oe});
    expect_port("gpio_o", 32'h5, {28'h0, gpio_o});
    bus(1'b1, {24'h0, REG_PROG_ADDR}, {22'h0, OTP_ATTR});
    bus(1'b1, {24'h0, REG_PROG_DATA}, 32'h0000_00C0);
    bus(1'b1, {24'h0, REG_PROG_ADDR}, {22'h0, OTP_SER_LEN});
    bus(1'b1, {24'h0, REG_PROG_DATA}, 32'h0000_003F);
    bus(1'b1, {24'h0, REG_PROG_ADDR}, {22'h0, OTP_DESC_LEN});
    bus(1'b1, {24'h0, REG_PROG_DATA}, 32'h0000_007E);
    repeat (2) @(posedge hclk);
    expect_rd({24'h0, REG_DESC}, 32'h0000_00C0, "desc_prog");
    expect_rd({24'h0, REG_MODES}, 32'h7E3F_0000, "len_max");
    expect_rd({24'h0, REG_STATUS}, st(10'd382, 1'b0, 1'b1, 1'b0, 1'b1), "programmed");
    expect_port("susp_prog", 32'h0, {30'h0, susp_pp, susp_n_pp});
    bus(1'b1, {24'h0, REG_CFG_ADDR}, {22'h0, OTP_ATTR});
    @(posedge hclk);
    expect_rd({24'h0, REG_CFG_DATA}, 32'h0000_00C0, "cfg_byte");
    // Pin 2 in its alternate mode shows the transceiver control while sending
    bus(1'b1, {24'h0, REG_PROG_ADDR}, {22'h0, OTP_GPIO});
    bus(1'b1, {24'h0, REG_PROG_DATA}, 32'h0000_0030);
    tx_busy <= 1'b1;
    repeat (2) @(negedge hclk);
    expect_port("xcvr_pin", 32'h5, {28'h0, gpio_o});
    expect_port("xcvr_oe", 32'h4, {28'h0, gpio_oe});
    @(posedge hclk);
    finish_test();
  end
endmodule : tb
